// ---- design/mmd_space.sv ----
// One device register space of the indirect access path.
`include "phy_mmd_regs.svh"
module mmd_space #(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wrEn,
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);

    logic [15:0] mem [DEPTH];

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= `ACC_DATA_RESET;
            end
        end
        else if (wrEn)
        begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];

endmodule : mmd_space

// ---- design/phy_mmd_access_and_function_ctrl.sv ----
// APB register bank for indirect device-space access and function control.
//
// The implementer's own choice: the APB slave port.
`include "phy_mmd_regs.svh"

// Notes on behaviour
// - Function 11 increments address after writes only.
// - Function 00 address, 01 plain, 10 increments always.
// - Device address selects spaces 1, 3, 7.
// - Function 00: data register holds the address.
// - Other functions: data register reaches stored address.
// - Extended status reads only bit 13 set.
// - Crossover field resets to auto, four encodings.
// - New crossover mode waits for software reset.
// - Carrier on transmit only when bit 3 set.
// - Bit 2 enables heartbeat test, srst clears it (software reset does not).
// - Heartbeat test suppressed in full duplex.
module phy_mmd_access_and_function_ctrl #(
    parameter int MMD_DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire phy_mmd_pkg::lineState_t lineState,
    output phy_mmd_pkg::lineCtrl_t lineCtrl
);

    localparam int AW = $clog2(MMD_DEPTH);
    localparam int NSPACE = 3;

    logic [1:0] accFunc_r;
    logic [4:0] devAddr_r;
    logic [15:0] mmdAddr_r;
    logic [1:0] crossPend_r;
    logic [1:0] crossAct_r;
    logic crsOnTx_r;
    logic sqeEn_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    phy_mmd_pkg::lineCtrl_t lineCtrl_r;

    logic setupPh;
    logic accessPh;
    logic wrAcc;
    logic [5:0] regIdx;
    logic mapped;
    logic dataAcc;
    logic dataWr;
    logic swRstPulse;
    logic inRange;
    logic [NSPACE-1:0] spaceSel;
    logic [15:0] spaceRd [NSPACE];
    logic [15:0] memRd;
    logic [31:0] rdMux;
    logic crsModeOk;

    assign setupPh = psel && !penable;
    assign accessPh = psel && penable;
    assign wrAcc = accessPh && pwrite;
    assign regIdx = paddr[7:2];
    assign pready = accessPh;
    assign prdata = prdata_r;
    assign pslverr = accessPh && pslverr_r;
    assign lineCtrl = lineCtrl_r;

    always_comb
    begin
        case (regIdx)
            `IDX_SOFT_RESET, `IDX_ACC_CTRL, `IDX_ACC_DATA,
            `IDX_EXT_STATUS, `IDX_FUNC_CTRL, `IDX_LINE_STATUS:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
    end

    assign dataAcc = accessPh && (regIdx == `IDX_ACC_DATA);
    assign dataWr = dataAcc && pwrite && (accFunc_r != `FUNC_ADDRESS);
    assign swRstPulse = wrAcc && (regIdx == `IDX_SOFT_RESET)
        && pwdata[`SOFT_RESET_BIT];
    assign inRange = (32'(mmdAddr_r) < MMD_DEPTH);

    genvar g;
    generate
        for (g = 0; g < NSPACE; g++)
        begin : g_space
            localparam logic [4:0] CODE = (g == 0) ? `DEVAD_MMD1 :
                (g == 1) ? `DEVAD_MMD3 : `DEVAD_MMD7;
            assign spaceSel[g] = (devAddr_r == CODE);
            mmd_space #(
                .DEPTH(MMD_DEPTH),
                .AW(AW)
            ) u_space (
                .sys_clk(sys_clk),
                .srst(srst),
                .wrEn(dataWr && spaceSel[g] && inRange),
                .addr(mmdAddr_r[AW-1:0]),
                .wdata(pwdata[15:0]),
                .rdata(spaceRd[g])
            );
        end
    endgenerate

    always_comb
    begin
        memRd = `ACC_DATA_RESET;
        for (int i = 0; i < NSPACE; i++)
        begin
            if (spaceSel[i] && inRange)
            begin
                memRd = memRd | spaceRd[i];
            end
        end
    end

    // read back address in address mode
    always_comb
    begin
        rdMux = `ZERO_WORD;
        case (regIdx)
            `IDX_ACC_CTRL:
            begin
                rdMux[`FUNC_HI:`FUNC_LO] = accFunc_r;
                rdMux[`DEVAD_HI:`DEVAD_LO] = devAddr_r;
            end
            `IDX_ACC_DATA:
            begin
                rdMux[15:0] = (accFunc_r == `FUNC_ADDRESS) ? mmdAddr_r
                    : memRd;
            end
            `IDX_EXT_STATUS:
            begin
                rdMux[15:0] = `EXT_STATUS_VALUE;
            end
            `IDX_FUNC_CTRL:
            begin
                rdMux[`CROSS_HI:`CROSS_LO] = crossPend_r;
                rdMux[`CRS_ON_TX_BIT] = crsOnTx_r;
                rdMux[`SQE_TEST_BIT] = sqeEn_r;
            end
            `IDX_LINE_STATUS:
            begin
                rdMux[`LINE_CROSS_HI:`LINE_CROSS_LO] = lineCtrl_r.crossoverMode;
                rdMux[`LINE_CRS_BIT] = lineCtrl_r.carrierSense;
                rdMux[`LINE_HB_BIT] = lineCtrl_r.heartbeatEnable;
            end
            default:
                rdMux = `ZERO_WORD;
        endcase
    end

    // Read data and error are captured in the setup cycle.
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            prdata_r <= `ZERO_WORD;
            pslverr_r <= 1'b0;
        end
        else if (setupPh)
        begin
            prdata_r <= pwrite ? `ZERO_WORD : rdMux;
            pslverr_r <= !mapped;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            accFunc_r <= `ACC_FUNC_RESET;
            devAddr_r <= `ACC_DEVAD_RESET;
        end
        else if (wrAcc && (regIdx == `IDX_ACC_CTRL))
        begin
            accFunc_r <= pwdata[`FUNC_HI:`FUNC_LO];
            devAddr_r <= pwdata[`DEVAD_HI:`DEVAD_LO];
        end
    end

    // post increment after the data access
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            mmdAddr_r <= `ACC_DATA_RESET;
        end
        else if (dataAcc)
        begin
            case (accFunc_r)
                `FUNC_ADDRESS:
                begin
                    if (pwrite)
                    begin
                        mmdAddr_r <= pwdata[15:0];
                    end
                end
                `FUNC_DATA_INC_RW:
                begin
                    mmdAddr_r <= mmdAddr_r + `ADDR_STEP;
                end
                `FUNC_DATA_INC_WR:
                begin
                    if (pwrite)
                    begin
                        mmdAddr_r <= mmdAddr_r + `ADDR_STEP;
                    end
                end
                default:
                    mmdAddr_r <= mmdAddr_r;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            crossPend_r <= `CROSS_AUTO;
            crsOnTx_r <= 1'b0;
            sqeEn_r <= 1'b0;
        end
        else if (wrAcc && (regIdx == `IDX_FUNC_CTRL))
        begin
            crossPend_r <= pwdata[`CROSS_HI:`CROSS_LO];
            crsOnTx_r <= pwdata[`CRS_ON_TX_BIT];
            sqeEn_r <= pwdata[`SQE_TEST_BIT];
        end
    end

    // crossover mode applied on software reset
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            crossAct_r <= `CROSS_AUTO;
        end
        else if (swRstPulse && (crossPend_r != `CROSS_RESERVED))
        begin
            crossAct_r <= crossPend_r;
        end
    end

    assign crsModeOk = (lineState.speed == `SPEED_100)
        || ((lineState.speed == `SPEED_10) && !lineState.fullDuplex);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            lineCtrl_r <= '0;
        end
        else
        begin
            lineCtrl_r.crossoverMode <= crossAct_r;
            lineCtrl_r.carrierSense <= lineState.rxActive
                || (lineState.txActive && crsOnTx_r && crsModeOk);
            lineCtrl_r.heartbeatEnable <= sqeEn_r && !lineState.fullDuplex;
        end
    end

    a_incr_write_only: assert property (
        @(posedge sys_clk) disable iff (srst)
        (dataAcc && accFunc_r == `FUNC_DATA_INC_WR)
        |=> (mmdAddr_r == ($past(pwrite) ? 16'($past(mmdAddr_r) + 1)
            : $past(mmdAddr_r))))
        else $error("address step wrong for write-only increment");

    a_incr_both: assert property (
        @(posedge sys_clk) disable iff (srst)
        (dataAcc && accFunc_r == `FUNC_DATA_INC_RW)
        |=> mmdAddr_r == 16'($past(mmdAddr_r) + 1))
        else $error("address not stepped after data access");

    a_devad_decode: assert property (
        @(posedge sys_clk) disable iff (srst)
        $countones(spaceSel) <= 1
        && ((devAddr_r == `DEVAD_MMD7) == spaceSel[2]))
        else $error("device space decode wrong");

    a_addr_mode_read: assert property (
        @(posedge sys_clk) disable iff (srst)
        (setupPh && !pwrite && regIdx == `IDX_ACC_DATA
            && accFunc_r == `FUNC_ADDRESS)
        |=> prdata[15:0] == $past(mmdAddr_r))
        else $error("address mode read does not return address");

    a_data_mode_read: assert property (
        @(posedge sys_clk) disable iff (srst)
        (setupPh && !pwrite && regIdx == `IDX_ACC_DATA
            && accFunc_r != `FUNC_ADDRESS)
        |=> prdata[15:0] == $past(memRd))
        else $error("data mode read does not return register");

    a_ext_status: assert property (
        @(posedge sys_clk) disable iff (srst)
        (setupPh && !pwrite && regIdx == `IDX_EXT_STATUS)
        |=> prdata == 32'h0000_2000)
        else $error("extended status value wrong");

    a_cross_reset: assert property (
        @(posedge sys_clk)
        $past(srst) |-> crossAct_r == 2'h3 && crossPend_r == 2'h3)
        else $error("crossover mode not automatic after reset");

    a_cross_hold: assert property (
        @(posedge sys_clk) disable iff (srst)
        !swRstPulse |=> $stable(crossAct_r))
        else $error("crossover mode changed without software reset");

    a_crs_tx: assert property (
        @(posedge sys_clk) disable iff (srst)
        (!lineState.rxActive && lineState.txActive && !crsOnTx_r)
        |=> !lineCtrl.carrierSense)
        else $error("carrier sense asserted on transmit while disabled");

    a_sqe_full: assert property (
        @(posedge sys_clk) disable iff (srst)
        lineState.fullDuplex |=> !lineCtrl.heartbeatEnable)
        else $error("heartbeat test enabled in full duplex");

    a_sqe_enable: assert property (
        @(posedge sys_clk) disable iff (srst)
        (sqeEn_r && !lineState.fullDuplex) |=> lineCtrl.heartbeatEnable)
        else $error("heartbeat test not enabled");

endmodule : phy_mmd_access_and_function_ctrl

// ---- design/phy_mmd_pkg.sv ----
// Types shared by the indirect access and function control bank.
package phy_mmd_pkg;

    typedef struct packed {
        logic [1:0] speed;
        logic fullDuplex;
        logic txActive;
        logic rxActive;
    } lineState_t;

    typedef struct packed {
        logic [1:0] crossoverMode;
        logic carrierSense;
        logic heartbeatEnable;
    } lineCtrl_t;

endpackage : phy_mmd_pkg

// ---- design/phy_mmd_regs.svh ----
// Register indices, field positions, reset values and codes of the bank.
`ifndef PHY_MMD_REGS_SVH
`define PHY_MMD_REGS_SVH

`define IDX_SOFT_RESET 6'h00
`define IDX_ACC_CTRL 6'h0D
`define IDX_ACC_DATA 6'h0E
`define IDX_EXT_STATUS 6'h0F
`define IDX_FUNC_CTRL 6'h10
`define IDX_LINE_STATUS 6'h1F

`define FUNC_HI 15
`define FUNC_LO 14
`define DEVAD_HI 4
`define DEVAD_LO 0
`define CROSS_HI 6
`define CROSS_LO 5
`define CRS_ON_TX_BIT 3
`define SQE_TEST_BIT 2
`define SOFT_RESET_BIT 15

`define FUNC_ADDRESS 2'h0
`define FUNC_DATA 2'h1
`define FUNC_DATA_INC_RW 2'h2
`define FUNC_DATA_INC_WR 2'h3

`define DEVAD_MMD1 5'h01
`define DEVAD_MMD3 5'h03
`define DEVAD_MMD7 5'h07

`define CROSS_STRAIGHT 2'h0
`define CROSS_CROSSED 2'h1
`define CROSS_RESERVED 2'h2
`define CROSS_AUTO 2'h3

`define SPEED_10 2'h0
`define SPEED_100 2'h1

`define EXT_STATUS_VALUE 16'h2000
`define ACC_CTRL_RESET 16'h0000
`define ACC_DATA_RESET 16'h0000
`define ADDR_STEP 16'h0001
`define ZERO_WORD 32'h0000_0000
`define ACC_FUNC_RESET 2'h0
`define ACC_DEVAD_RESET 5'h00
`define LINE_CROSS_HI 3
`define LINE_CROSS_LO 2
`define LINE_CRS_BIT 1
`define LINE_HB_BIT 0

`endif

// ---- verification/mgmt_master.sv ----
// Management master model that drives APB transfers into the bank.
`include "phy_mmd_regs.svh"
module mgmt_master (
    input wire logic sys_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // Holds the request until pready is sampled, then scrambles the bus.
    task automatic xfer(input logic w, input logic [5:0] idx,
        input logic [15:0] d, output logic [31:0] q, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer

    task automatic sel(input logic [4:0] dv, input logic [15:0] a,
        input logic [1:0] f);
        logic [31:0] q;
        logic e;
        xfer(1'b1, `IDX_ACC_CTRL, {`FUNC_ADDRESS, 9'h000, dv}, q, e);
        xfer(1'b1, `IDX_ACC_DATA, a, q, e);
        xfer(1'b1, `IDX_ACC_CTRL, {f, 9'h000, dv}, q, e);
    endtask : sel
endmodule : mgmt_master

// ---- verification/testbench.sv ----
// Self-checking bench for the indirect access and function control bank.
`include "phy_mmd_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    phy_mmd_pkg::lineState_t lineState;
    phy_mmd_pkg::lineCtrl_t lineCtrl;
    int n_errors, compares;

    phy_mmd_access_and_function_ctrl u_phy_mmd_access_and_function_ctrl (
        .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lineState(lineState),
        .lineCtrl(lineCtrl));
    mgmt_master u_mgmt_master (
        .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] idx, input logic [15:0] d);
        logic [31:0] q;
        logic e;
        u_mgmt_master.xfer(1'b1, idx, d, q, e);
    endtask : wr

    task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp,
        input logic ee = 1'b0);
        logic [31:0] q;
        logic e;
        u_mgmt_master.xfer(1'b0, idx, 16'h0000, q, e);
        chk(q, exp);
        chk({31'h0000_0000, e}, {31'h0000_0000, ee});
    endtask : rdchk

    task automatic ctl(input logic [1:0] f, input logic [4:0] dv);
        wr(`IDX_ACC_CTRL, {f, 9'h000, dv});
    endtask : ctl

    task automatic t_reset;
        rdchk(`IDX_ACC_CTRL, 32'h0000_0000);
        rdchk(`IDX_ACC_DATA, 32'h0000_0000);
        wr(`IDX_EXT_STATUS, 16'hFFFF);
        rdchk(`IDX_EXT_STATUS, 32'h0000_2000);
        rdchk(`IDX_FUNC_CTRL, 32'h0000_0060);
        rdchk(`IDX_LINE_STATUS, 32'h0000_000C);
        rdchk(6'h05, 32'h0000_0000, 1'b1);
        wr(`IDX_ACC_CTRL, 16'hFFFF);
        rdchk(`IDX_ACC_CTRL, 32'h0000_C01F);
    endtask : t_reset

    task automatic t_spaces;
        logic [4:0] dv[3] = '{`DEVAD_MMD1, `DEVAD_MMD3, `DEVAD_MMD7};
        for (int i = 0; i < 3; i++)
        begin
            u_mgmt_master.sel(dv[i], 16'h0005, `FUNC_DATA);
            wr(`IDX_ACC_DATA, 16'hA000 + 16'(i));
        end
        for (int i = 0; i < 3; i++)
        begin
            u_mgmt_master.sel(dv[i], 16'h0005, `FUNC_DATA);
            rdchk(`IDX_ACC_DATA, 32'h0000_A000 + i);
            ctl(`FUNC_ADDRESS, dv[i]);
            rdchk(`IDX_ACC_DATA, 32'h0000_0005);
        end
        u_mgmt_master.sel(5'h02, 16'h0005, `FUNC_DATA);
        rdchk(`IDX_ACC_DATA, 32'h0000_0000);
    endtask : t_spaces

    task automatic t_incr;
        u_mgmt_master.sel(`DEVAD_MMD3, 16'h0008, `FUNC_DATA_INC_RW);
        wr(`IDX_ACC_DATA, 16'h1111);
        wr(`IDX_ACC_DATA, 16'h2222);
        rdchk(`IDX_ACC_DATA, 32'h0000_0000);
        ctl(`FUNC_ADDRESS, `DEVAD_MMD3);
        rdchk(`IDX_ACC_DATA, 32'h0000_000B);
        u_mgmt_master.sel(`DEVAD_MMD3, 16'h0008, `FUNC_DATA_INC_WR);
        rdchk(`IDX_ACC_DATA, 32'h0000_1111);
        rdchk(`IDX_ACC_DATA, 32'h0000_1111);
        wr(`IDX_ACC_DATA, 16'h3333);
        rdchk(`IDX_ACC_DATA, 32'h0000_2222);
        ctl(`FUNC_ADDRESS, `DEVAD_MMD3);
        rdchk(`IDX_ACC_DATA, 32'h0000_0009);
    endtask : t_incr

    task automatic t_cross;
        logic [1:0] md[4] = '{`CROSS_CROSSED, `CROSS_STRAIGHT,
            `CROSS_RESERVED, `CROSS_AUTO};
        logic [1:0] ex[4] = '{2'h1, 2'h0, 2'h0, 2'h3};
        logic [1:0] act = 2'h3;
        for (int i = 0; i < 4; i++)
        begin
            wr(`IDX_FUNC_CTRL, {9'h000, md[i], 5'h00});
            rdchk(`IDX_FUNC_CTRL, {25'h000_0000, md[i], 5'h00});
            chk({30'h0, lineCtrl.crossoverMode}, {30'h0, act});
            wr(`IDX_SOFT_RESET, 16'h8000);
            repeat (2) @(posedge sys_clk);
            act = ex[i];
            chk({30'h0, lineCtrl.crossoverMode}, {30'h0, act});
        end
    endtask : t_cross

    task automatic t_line;
        logic [8:0] rows[9] = '{9'h12A, 9'h028, 9'h10A, 9'h118, 9'h148,
            9'h081, 9'h090, 9'h0C7, 9'h13A};
        for (int i = 0; i < 9; i++)
        begin
            wr(`IDX_FUNC_CTRL, {9'h000, 3'h6, rows[i][8:7], 2'h0});
            @(posedge sys_clk);
            lineState <= rows[i][6:2];
            repeat (3) @(posedge sys_clk);
            chk(32'(lineCtrl.carrierSense), 32'(rows[i][1]));
            chk(32'(lineCtrl.heartbeatEnable), 32'(rows[i][0]));
            rdchk(`IDX_LINE_STATUS, {28'h0, 2'h3, rows[i][1:0]});
        end
    endtask : t_line

    task automatic report_and_stop;
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        #100000;
        n_errors++;
        report_and_stop;
    end

    initial
    begin
        srst = 1'b1;
        lineState = '0;
        n_errors = 0;
        compares = 0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset;
        t_spaces;
        t_incr;
        t_cross;
        t_line;
        report_and_stop;
    end
endmodule : testbench
